// *** logic/chain_spi_pkg.sv ***
// Purpose: shared constants for the chained three-byte serial register port
// Assumes: system clock of 200 MHz, serial clock made by the master end
// Notes:   both link ends use these names; the joining interface does not
`default_nettype none

package chain_spi_pkg;

  // ----------------------------------------------------------------------
  // packet framing
  // ----------------------------------------------------------------------
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned PACKET_BYTES   = 3;
  localparam logic [3:0]  BIT_CNT_FULL   = 4'h8;   // bits in one byte
  localparam logic [3:0]  CID_FIRST_BIT  = 4'h3;   // bits before the id field
  localparam logic [1:0]  BYTE_CONTROL   = 2'h0;
  localparam logic [1:0]  BYTE_ADDRESS   = 2'h1;
  localparam logic [1:0]  BYTE_DATA      = 2'h2;

  // ----------------------------------------------------------------------
  // control byte layout
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_BROADCAST_BIT = 7;   // broadcast_flag
  localparam int unsigned CTL_READ_BIT      = 6;   // read_not_write
  localparam int unsigned CTL_RESERVED_BIT  = 5;   // control_reserved_bit
  localparam int unsigned CID_WIDTH         = 5;   // chain_position_id, reversed
  localparam logic [4:0]  CID_ACTIVE        = 5'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned SCLK_PERIOD_NS = 80;
  localparam int unsigned HALF_CYC_DEF   =
    (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES    = 3;

endpackage

`default_nettype wire

// *** logic/chain_spi_if.sv ***
// Purpose: wires between the serial master end and the register port end
// Assumes: slave output line is pulled low when nobody drives it
// Notes:   the line level is resolved here from the output enable
`default_nettype none

interface chain_spi_if;

  // ----------------------------------------------------------------------
  // link signals
  // ----------------------------------------------------------------------
  logic sel_n;          // device select, low while a byte is framed
  logic sclk;           // serial clock from the master
  logic mosi;           // master-out data
  logic miso_drv;       // slave output value
  logic miso_oe;        // slave output enable, high while driving
  logic miso;           // resolved slave output line
  logic chain_data_out; // forwarded stream toward the next device

  // pull-down stands in for the idle line
  assign miso = miso_oe ? miso_drv : 1'b0;

  modport device (
    input  sel_n,
    input  sclk,
    input  mosi,
    output miso_drv,
    output miso_oe,
    output chain_data_out
  );

  modport master (
    output sel_n,
    output sclk,
    output mosi,
    input  miso
  );

endinterface

`default_nettype wire

// *** logic/chain_spi_device.sv ***
// Purpose: register port end of the chained three-byte serial link
// Assumes: link pins are asynchronous to clk; sclk well below clk/8
// Notes:   register bank sits outside; it answers reg_valid and reg_rdata
//
// Function
// (R1) packet is control, address, data bytes
// (R2) second byte is register address, msb first
// (R3) sample bits on rising sclk, select low
// (R4) select deassert after eight bits advances byte
// (R5) drive slave output only in read data
// (R6) bad bit count loses framing alignment
// (R7) sclk rise with select high resets packet
// (R8) master resyncs by clocking with select high
// (R9) abandoned write leaves register unchanged
// (R10) over-clocked data byte need not be guarded
// (R11) master repeats broken writes after resync; chain_spi_master never repeats a packet
// (R12) control bit six chooses read or write
// (R13) broadcast flag ignored on reads
// (R14) unimplemented read address returns zero
// (R15) broadcast write updates every chained device
// (R16) unimplemented write address changes nothing
// (R17) slave output stays off during writes
// (R18) single device gets all-zero chain id
// (R19) forwarded chain id is decremented by one
// (R20) chain id sent reversed, lsb at bit four
// (R21) device is target only when id zero
// (R22) all other bits forwarded unchanged
// (R23) reserved control bit ignored when decoding
// (R24) write strobe only after full data byte
`default_nettype none

module chain_spi_device (
  input  wire logic       clk,
  input  wire logic       rst,
  chain_spi_if.device     link,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_we,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_valid,
  output logic            frame_lost
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sclk_s;     // synchroniser chains, [0] is the first stage
    logic [2:0] sel_s;
    logic [2:0] mosi_s;
    logic       sclk_f;     // filtered pin levels
    logic       sel_f;
    logic       mosi_f;
    logic [3:0] bit_cnt;    // bits taken in the current byte
    logic [1:0] byte_idx;   // byte of the packet expected next
    logic       lost;       // framing broken, wait for resync
    logic       borrow;     // serial decrement borrow for the chain id
    logic       flip;       // invert the bit now on the chain output
    logic [7:0] shift_in;
    logic [7:0] ctl;
    logic [7:0] shift_out;
    logic       load_rd;    // fetch read data one cycle after address
    logic       miso;
    logic       miso_oe;
    logic       chain_out;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } dev_s;

  dev_s r;
  dev_s n;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // a change counts only once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[1] : cur;
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic cid_zero;
  logic is_read;
  logic wr_go;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.we = 1'b0;
    // stage one feeds only stage two
    n.sclk_s = {r.sclk_s[1:0], link.sclk};
    n.sel_s  = {r.sel_s[1:0], link.sel_n};
    n.mosi_s = {r.mosi_s[1:0], link.mosi};
    n.sclk_f = filt(r.sclk_s, r.sclk_f);
    n.sel_f  = filt(r.sel_s, r.sel_f);
    n.mosi_f = filt(r.mosi_s, r.mosi_f);

    sclk_rise = n.sclk_f & ~r.sclk_f;
    sclk_fall = ~n.sclk_f & r.sclk_f;
    sel_fall  = ~n.sel_f & r.sel_f;
    sel_rise  = n.sel_f & ~r.sel_f;

    // reversed id: any set bit means some other device is the target
    cid_zero = (r.ctl[chain_spi_pkg::CID_WIDTH-1:0] == chain_spi_pkg::CID_ACTIVE); // R21 R20
    // bit five plays no part in the decode
    is_read  = r.ctl[chain_spi_pkg::CTL_READ_BIT]; // R12 R23
    wr_go    = ~is_read & (r.ctl[chain_spi_pkg::CTL_BROADCAST_BIT] | cid_zero) // R15
               & reg_valid; // R16

    // read data captured after the bank has seen the new address
    if (r.load_rd)
    begin
      n.shift_out = reg_valid ? reg_rdata : 8'h00; // R14
      n.load_rd   = 1'b0;
    end

    if (sclk_rise)
    begin
      if (n.sel_f)
      begin
        // clocking with select high restarts the packet
        n.byte_idx = chain_spi_pkg::BYTE_CONTROL; // R7 R8
        n.bit_cnt  = 4'h0;
        n.lost     = 1'b0;
        n.borrow   = 1'b1;
      end
      else if (!r.lost)
      begin
        if (r.bit_cnt == chain_spi_pkg::BIT_CNT_FULL)
        begin
          // a ninth edge: drop the packet instead of risking a write
          n.lost = 1'b1; // R6 R10
        end
        else
        begin
          n.shift_in = {r.shift_in[6:0], r.mosi_f}; // R3 R2
          n.bit_cnt  = r.bit_cnt + 4'h1;
          if (r.byte_idx == chain_spi_pkg::BYTE_CONTROL &&
              r.bit_cnt >= chain_spi_pkg::CID_FIRST_BIT)
          begin
            n.borrow = r.borrow & ~r.mosi_f; // R19 R20
          end
        end
      end
    end

    // next read bit goes out on the falling edge
    if (sclk_fall && !n.sel_f)
    begin
      n.shift_out = {r.shift_out[6:0], 1'b0};
    end

    // the id bit on the wire is known from the count at each falling edge
    if ((sclk_fall && !n.sel_f) || sel_fall)
    begin
      n.flip = (n.byte_idx == chain_spi_pkg::BYTE_CONTROL) &&
               (n.bit_cnt >= chain_spi_pkg::CID_FIRST_BIT) &&
               (n.bit_cnt < chain_spi_pkg::BIT_CNT_FULL) && n.borrow; // R19
    end

    if (sel_fall)
    begin
      n.bit_cnt = 4'h0;
    end

    if (sel_rise)
    begin
      n.flip    = 1'b0;
      n.bit_cnt = 4'h0;
      if (!r.lost)
      begin
        if (r.bit_cnt != chain_spi_pkg::BIT_CNT_FULL)
        begin
          // short byte: abandon, nothing is written
          n.lost = 1'b1; // R6 R9
        end
        else
        begin
          unique case (r.byte_idx) // R1 R4
            chain_spi_pkg::BYTE_CONTROL:
            begin
              n.ctl      = r.shift_in;
              n.byte_idx = chain_spi_pkg::BYTE_ADDRESS;
            end
            chain_spi_pkg::BYTE_ADDRESS:
            begin
              n.addr     = r.shift_in; // R2
              n.load_rd  = 1'b1;
              n.byte_idx = chain_spi_pkg::BYTE_DATA;
            end
            chain_spi_pkg::BYTE_DATA:
            begin
              n.wdata    = r.shift_in;
              n.we       = wr_go; // R24 R9
              n.byte_idx = chain_spi_pkg::BYTE_CONTROL;
              n.borrow   = 1'b1;
            end
            default:
            begin
              n.lost = 1'b1;
            end
          endcase
        end
      end
    end

    // only the addressed device answers a read; broadcast has no say
    n.miso_oe = ~n.sel_f & ~n.lost & (n.byte_idx == chain_spi_pkg::BYTE_DATA) &
                n.ctl[chain_spi_pkg::CTL_READ_BIT] &
                (n.ctl[chain_spi_pkg::CID_WIDTH-1:0] == chain_spi_pkg::CID_ACTIVE); // R5 R13 R17
    n.miso      = n.shift_out[7];
    n.chain_out = n.mosi_f ^ n.flip; // R22 R19
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r          <= '0;
      r.sclk_s   <= 3'h0;
      r.sel_s    <= 3'h7;   // select idles high
      r.sel_f    <= 1'b1;
      r.borrow   <= 1'b1;
      r.lost     <= 1'b1;   // first packet must follow a resync
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign link.miso_drv       = r.miso;
  assign link.miso_oe        = r.miso_oe;
  assign link.chain_data_out = r.chain_out;
  assign reg_addr            = r.addr;
  assign reg_wdata           = r.wdata;
  assign reg_we              = r.we;
  assign frame_lost          = r.lost;

endmodule

`default_nettype wire

// *** logic/chain_spi_master.sv ***
// Purpose: serial master end that frames three-byte register packets
// Assumes: serial clock made here by dividing clk
// Notes:   one packet at a time; start is ignored while busy
`default_nettype none

module chain_spi_master #(
  parameter int unsigned HALF_CYC = chain_spi_pkg::HALF_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  chain_spi_if.master     link,
  input  wire logic       start,
  input  wire logic       resync,
  input  wire logic [7:0] ctl_byte,
  input  wire logic [7:0] addr_byte,
  input  wire logic [7:0] wdata_byte,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdata
);

  // ----------------------------------------------------------------------
  // checks and state
  // ----------------------------------------------------------------------
  if (HALF_CYC < 8 || HALF_CYC > 255)
  begin : g_bad_half
    $error("HALF_CYC must lie in 8..255 for the pin filters to settle");
  end

  localparam logic [7:0] HALF = 8'(HALF_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RSY_HI = 3'b001,
    ST_RSY_LO = 3'b010,
    ST_SEL    = 3'b011,
    ST_HI     = 3'b100,
    ST_LO     = 3'b101,
    ST_TAIL   = 3'b110,
    ST_DESEL  = 3'b111
  } mst_e;

  typedef struct packed {
    mst_e       st;
    logic [7:0] tmr;
    logic [1:0] byte_idx;
    logic [2:0] bit_idx;
    logic [23:0] tx;        // remaining packet bits, msb first
    logic [7:0] rx;
    logic [2:0] miso_s;
    logic       miso_f;
    logic       sel_n;
    logic       sclk;
    logic       mosi;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
  } mst_s;

  mst_s r;
  mst_s n;
  logic tick;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.done   = 1'b0;
    n.miso_s = {r.miso_s[1:0], link.miso};
    n.miso_f = (r.miso_s[1] == r.miso_s[2]) ? r.miso_s[1] : r.miso_f;
    tick     = (r.tmr == HALF);
    n.tmr    = tick ? 8'h00 : r.tmr + 8'h01;
    unique case (r.st)
      ST_IDLE:
      begin
        n.tmr = 8'h00;
        if (start)
        begin
          n.busy     = 1'b1;
          n.tx       = {ctl_byte, addr_byte, wdata_byte}; // R1
          n.byte_idx = chain_spi_pkg::BYTE_CONTROL;
          n.bit_idx  = 3'h0;
          n.rx       = 8'h00;
          if (resync)
          begin
            n.st   = ST_RSY_HI;
            n.sclk = 1'b1; // R8
          end
          else
          begin
            n.st    = ST_SEL;
            n.sel_n = 1'b0;
            n.mosi  = ctl_byte[7];
          end
        end
      end
      ST_RSY_HI:
      begin
        if (tick)
        begin
          n.sclk = 1'b0;
          n.st   = ST_RSY_LO;
        end
      end
      ST_RSY_LO:
      begin
        if (tick)
        begin
          n.sel_n = 1'b0;
          n.mosi  = r.tx[23];
          n.st    = ST_SEL;
        end
      end
      ST_SEL, ST_LO:
      begin
        if (tick)
        begin
          n.sclk = 1'b1;
          n.st   = ST_HI;
        end
      end
      ST_HI:
      begin
        // sample just before the falling edge: the far end's filter and ours
        // together take about eight clocks, too long to meet the rising edge
        if (tick)
        begin
          n.rx      = {r.rx[6:0], r.miso_f};
          n.sclk    = 1'b0;
          n.tx      = {r.tx[22:0], 1'b0};
          n.mosi    = r.tx[22];
          n.bit_idx = r.bit_idx + 3'h1;
          n.st      = (r.bit_idx == 3'h7) ? ST_TAIL : ST_LO;
        end
      end
      ST_TAIL:
      begin
        if (tick)
        begin
          n.sel_n = 1'b1; // R4
          n.st    = ST_DESEL;
        end
      end
      ST_DESEL:
      begin
        if (tick)
        begin
          if (r.byte_idx == chain_spi_pkg::BYTE_DATA)
          begin
            n.st    = ST_IDLE;
            n.busy  = 1'b0;
            n.done  = 1'b1;
            n.rdata = r.rx;
          end
          else
          begin
            n.byte_idx = r.byte_idx + 2'h1;
            n.sel_n    = 1'b0;
            n.mosi     = r.tx[23];
            n.st       = ST_SEL;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.sel_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign link.sel_n = r.sel_n;
  assign link.sclk  = r.sclk;
  assign link.mosi  = r.mosi;
  assign busy       = r.busy;
  assign done       = r.done;
  assign rdata      = r.rdata;

endmodule

`default_nettype wire

// *** testbench/chain_spi_chk.sv ***
// Purpose: link checker for the master and device ends joined by one interface
// Assumes: master half period of 8 clk, single clk domain
// Notes:   a shadow byte counter follows the packet so the output enable can be judged
`default_nettype none

module chain_spi_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       sclk_q;
  logic       sel_q;
  logic [3:0] rise_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift_r;
  logic       rd_r;
  wire        rise = sclk & ~sclk_q;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // shadow framing: bit count, byte index and read-target flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    sclk_q <= sclk;
    sel_q  <= sel_n;
    if (rst)
    begin
      rise_cnt <= 4'h0;
      byte_idx <= 2'h0;
      rd_r     <= 1'b0;
    end
    else if (sel_n && rise)
    begin
      rise_cnt <= 4'h0;
      byte_idx <= 2'h0;
    end
    else if (sel_n && !sel_q)
    begin
      rise_cnt <= 4'h0;
      if (rise_cnt == 4'h8)
      begin
        byte_idx <= (byte_idx == 2'h2) ? 2'h0 : byte_idx + 2'h1;
        // broadcast bit left out on purpose: reads ignore it
        if (byte_idx == 2'h0) rd_r <= shift_r[6] && (shift_r[4:0] == 5'h00);
      end
    end
    else if (!sel_n && rise)
    begin
      rise_cnt <= rise_cnt + 4'h1;
      shift_r  <= {shift_r[6:0], mosi};
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_OE_SEL_HIGH: assert property (sel_n [*8] |-> !miso_oe)
    else $error("slave output enabled long after select rose");
  AST_OE_ROSE_SEL: assert property ($rose(miso_oe) |-> !sel_n)
    else $error("slave output enabled while select high");
  AST_SEL_SCLK_LOW: assert property ($changed(sel_n) |-> !sclk)
    else $error("select moved while serial clock high");
  AST_MOSI_STABLE: assert property (!sel_n && $rose(sclk) |-> $stable(mosi))
    else $error("master data moved at sampling edge");
  AST_MISO_STABLE: assert property (miso_oe && $rose(sclk) |-> $stable(miso_drv))
    else $error("slave data moved at sampling edge");
  AST_BIT_COUNT: assert property ($rose(sel_n) |-> rise_cnt == 4'h8)
    else $error("byte closed without eight clock edges");
  AST_OE_ONLY_READ: assert property (miso_oe && !sel_n |-> byte_idx == 2'h2 && rd_r)
    else $error("slave output driven outside read data byte");
  AST_OE_ON_READ: assert property ($fell(sel_n) && byte_idx == 2'h2 && rd_r
    |-> ##[1:8] miso_oe)
    else $error("slave output not driven in read data byte");
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: bench joining both link ends plus a bit-banged second device
// Assumes: bank treats bit 7 clear as implemented, read data is addr ^ a5
// Notes:   second device gets malformed bytes on purpose
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // clock, reset and wiring
  // ----------------------------------------------------------------------
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        start      = 1'b0;
  logic        resync     = 1'b0;
  logic [7:0]  ctl_byte   = 8'h00;
  logic [7:0]  addr_byte  = 8'h00;
  logic [7:0]  wdata_byte = 8'h00;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        frame_lost;
  logic [7:0]  b_addr;
  logic [7:0]  b_wdata;
  logic        b_we;
  logic        b_lost;
  logic [23:0] chain_q    = 24'h0;
  int          we_cnt     = 0;
  int          b_we_cnt   = 0;
  int          error_cnt  = 0;
  int          checks     = 0;

  chain_spi_if lnk ();
  chain_spi_if lnk2 ();

  always #2.5 clk = ~clk;

  chain_spi_master #(.HALF_CYC(8)) chain_spi_master_inst (
    .clk(clk), .rst(rst), .link(lnk), .start(start), .resync(resync),
    .ctl_byte(ctl_byte), .addr_byte(addr_byte), .wdata_byte(wdata_byte),
    .busy(busy), .done(done), .rdata(rdata));
  // bank returns nonzero data for unimplemented places, so zeroing is the device's
  chain_spi_device chain_spi_device_inst (
    .clk(clk), .rst(rst), .link(lnk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_addr ^ 8'ha5), .reg_valid(~reg_addr[7]),
    .frame_lost(frame_lost));
  chain_spi_device chain_spi_device_inst2 (
    .clk(clk), .rst(rst), .link(lnk2), .reg_addr(b_addr), .reg_wdata(b_wdata),
    .reg_we(b_we), .reg_rdata(b_addr ^ 8'ha5), .reg_valid(~b_addr[7]),
    .frame_lost(b_lost));
  chain_spi_chk chain_spi_chk_inst (
    .clk(clk), .rst(rst), .sel_n(lnk.sel_n), .sclk(lnk.sclk), .mosi(lnk.mosi),
    .miso_drv(lnk.miso_drv), .miso_oe(lnk.miso_oe));

  // strobes counted on the falling edge, away from the edge that makes them
  always @(negedge clk)
  begin
    if (reg_we === 1'b1) we_cnt++;
    if (b_we === 1'b1) b_we_cnt++;
  end
  always @(posedge lnk.sclk)
  begin
    if (lnk.sel_n === 1'b0) chain_q <= {chain_q[22:0], lnk.chain_data_out};
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // reversed id field, decremented by one
  function automatic logic [7:0] fwd(input logic [7:0] c);
    logic [4:0] id;
    id = {c[0], c[1], c[2], c[3], c[4]} - 5'h01;
    return {c[7:5], id[0], id[1], id[2], id[3], id[4]};
  endfunction

  task automatic pkt(input logic rs, input logic [7:0] c, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    start      <= 1'b1;
    resync     <= rs;
    ctl_byte   <= c;
    addr_byte  <= a;
    wdata_byte <= d;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    chk("busy", 8'h01, {7'h00, busy});
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    chk("idle", 8'h00, {7'h00, busy});
    repeat (10) @(negedge clk);
    chk("chain ctl", fwd(c), chain_q[23:16]);
    chk("chain addr", a, chain_q[15:8]);
    chk("chain data", d, chain_q[7:0]);
  endtask

  // bit-banged byte with n clock edges, select framing around it
  task automatic bang(input logic [7:0] b, input int n);
    @(posedge clk);
    lnk2.sel_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      lnk2.mosi <= b[7 - (i % 8)];
      repeat (8) @(posedge clk);
      lnk2.sclk <= 1'b1;
      repeat (8) @(posedge clk);
      lnk2.sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    lnk2.sel_n <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic sync2();
    @(posedge clk);
    lnk2.sclk <= 1'b1;
    repeat (8) @(posedge clk);
    lnk2.sclk <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_fault();
    int w0;
    w0 = b_we_cnt;
    chk("lost at reset", 8'h01, {7'h00, b_lost});
    sync2();
    chk("lost cleared", 8'h00, {7'h00, b_lost});
    bang(8'h00, 8);
    bang(8'h34, 8);
    bang(8'h55, 7);
    chk("short lost", 8'h01, {7'h00, b_lost});
    chk("short no we", 8'h00, 8'(b_we_cnt - w0));
    sync2();
    bang(8'h00, 8);
    bang(8'h34, 8);
    bang(8'h5a, 8);
    chk("good we", 8'h01, 8'(b_we_cnt - w0));
    chk("good addr", 8'h34, b_addr);
    chk("good data", 8'h5a, b_wdata);
    // a ninth edge in the data byte must drop the packet, not write it
    sync2();
    bang(8'h00, 8);
    bang(8'h34, 8);
    bang(8'h77, 9);
    chk("ninth lost", 8'h01, {7'h00, b_lost});
    chk("ninth no we", 8'h01, 8'(b_we_cnt - w0));
    $display("test fault done");
  endtask

  task automatic t_write();
    int w0;
    w0 = we_cnt;
    pkt(1'b1, 8'h00, 8'h12, 8'h3c);
    chk("we count", 8'h01, 8'(we_cnt - w0));
    chk("wr addr", 8'h12, reg_addr);
    chk("wr data", 8'h3c, reg_wdata);
    chk("frame ok", 8'h00, {7'h00, frame_lost});
    $display("test write done");
  endtask

  task automatic t_read();
    int w0;
    w0 = we_cnt;
    pkt(1'b0, 8'h40, 8'h21, 8'h00);
    chk("rd valid", 8'h21 ^ 8'ha5, rdata);
    pkt(1'b0, 8'he0, 8'h05, 8'h00);
    chk("rd bcast", 8'h05 ^ 8'ha5, rdata);
    pkt(1'b0, 8'h40, 8'h81, 8'hff);
    chk("rd unimpl", 8'h00, rdata);
    chk("rd no we", 8'h00, 8'(we_cnt - w0));
    $display("test read done");
  endtask

  task automatic t_target();
    int w0;
    w0 = we_cnt;
    pkt(1'b0, 8'h08, 8'h13, 8'h66);
    chk("id 2 no we", 8'h00, 8'(we_cnt - w0));
    pkt(1'b0, 8'h50, 8'h22, 8'h00);
    chk("id 1 rd", 8'h00, rdata);
    pkt(1'b0, 8'h88, 8'h14, 8'h77);
    chk("bcast we", 8'h01, 8'(we_cnt - w0));
    chk("bcast data", 8'h77, reg_wdata);
    pkt(1'b0, 8'h00, 8'h90, 8'h99);
    chk("unimpl we", 8'h01, 8'(we_cnt - w0));
    $display("test target done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    lnk2.sel_n = 1'b1;
    lnk2.sclk  = 1'b0;
    lnk2.mosi  = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_fault();
    t_write();
    t_read();
    t_target();
    print_verdict();
  end

  // whole run is near 5000 cycles; this cuts a hang well past that
  initial
  begin
    #100us;
    error_cnt++;
    print_verdict();
  end
endmodule

`default_nettype wire
